/* File: cdm_host.sv */
// Host controller that drives the cached DRAM through its pins.
// Assumes a request is held until reqReady; data pins are sampled via sync.
`timescale 1ns/1ps
`include "cdm_cfg.svh"
module cdm_host #(
	parameter int ROW_W  = `CDM_ROW_W,
	parameter int COL_W  = `CDM_COL_W,
	parameter int DATA_W = `CDM_DATA_W
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  reqValid,
	output logic                       reqReady,
	input  wire cdm_pkg::cdm_op_t      reqOp,
	input  wire logic [ROW_W-1:0]      reqRow,
	input  wire logic [COL_W-1:0]      reqCol,
	input  wire logic [DATA_W-1:0]     reqData,
	input  wire logic                  reqCacheOnly,
	output logic                       rspValid,
	output logic [DATA_W-1:0]          rspData,
	output logic                       rspHit,
	output logic                       readHit,
	output logic                       readMiss,
	output logic [ROW_W-1:0]           lastReadRow,
	output logic                       lastReadRowValid,
	output logic                       row_enable_n,
	output logic                       write_read_sel,
	output logic                       refresh_n,
	output logic                       col_addr_latch_n,
	output logic                       data_strobe_n,
	output logic                       output_gate_n,
	output logic                       chip_sel_n,
	output logic [ROW_W-1:0]           mux_addr,
	input  wire logic [DATA_W-1:0]     data_io_in,
	output logic [DATA_W-1:0]          data_io_out,
	output logic                       data_io_oe
);
	import cdm_pkg::*;

	localparam logic [`CDM_CNT_W-1:0] C_RAC  =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_RAC_NS));
	localparam logic [`CDM_CNT_W-1:0] C_AC   =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_AC_NS));
	localparam logic [`CDM_CNT_W-1:0] C_RE   =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_RE_NS));
	localparam logic [`CDM_CNT_W-1:0] C_RE1  =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_RE1_NS));
	localparam logic [`CDM_CNT_W-1:0] C_RP   =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_RP_NS));
	localparam logic [`CDM_CNT_W-1:0] C_RP1  =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_RP1_NS));
	localparam logic [`CDM_CNT_W-1:0] C_RSW  =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_RSW_NS));
	localparam logic [`CDM_CNT_W-1:0] C_WP   =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_WP_NS));
	localparam logic [`CDM_CNT_W-1:0] C_WRR  =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_WRR_NS));
	localparam logic [`CDM_CNT_W-1:0] C_SU   =
		`CDM_CNT_W'(`CDM_CYC_MIN(`CDM_T_SETUP_NS));

	typedef enum {
		ST_IDLE, ST_SETUP, ST_RFALL, ST_RDATA, ST_WLATCH, ST_WEND,
		ST_RHOLD, ST_PRECH, ST_CREAD, ST_RECOV
	} cdm_state_t;

	cdm_tmr_if tmrBus ();
	cdm_wait_timer uTimer (
		.clk (clk),
		.rst (rst),
		.tmr (tmrBus.tmr)
	);

	cdm_state_t           state, next_state;
	cdm_op_t              op, next_op;
	logic [ROW_W-1:0]     row, next_row;
	logic [COL_W-1:0]     col, next_col;
	logic [DATA_W-1:0]    wdata, next_wdata;
	logic                 hit, next_hit;
	logic [`CDM_CNT_W-1:0] prech, next_prech;
	logic [ROW_W-1:0]     last_read_row_reg, next_lrr;
	logic                 lrrValid, next_lrrValid;
	logic                 reN, next_reN, wrSel, next_wrSel;
	logic                 refN, next_refN, calN, next_calN;
	logic                 weN, next_weN, gN, next_gN, sN, next_sN;
	logic [ROW_W-1:0]     addr, next_addr;
	logic                 oe, next_oe;
	logic                 rv, next_rv, rh, next_rh, rm, next_rm;
	logic [DATA_W-1:0]    rdat, next_rdat;
	logic [DATA_W-1:0]    dqMeta, dqSync;

	// Two flops before the returned data is used
	always_ff @(posedge clk) begin
		dqMeta <= data_io_in;
		dqSync <= dqMeta;
	end

	always_comb begin
		next_state = state;   next_op = op;       next_row = row;
		next_col = col;       next_wdata = wdata; next_hit = hit;
		next_prech = prech;   next_lrr = last_read_row_reg;     next_lrrValid = lrrValid;
		next_reN = reN;       next_wrSel = wrSel; next_refN = refN;
		next_calN = calN;     next_weN = weN;     next_gN = gN;
		next_sN = sN;         next_addr = addr;   next_oe = oe;
		next_rdat = rdat;     next_rv = 1'b0;     next_rh = 1'b0;
		next_rm = 1'b0;       tmrBus.load = 1'b0; tmrBus.count = C_SU;
		reqReady = 1'b0;
		case (state)
			ST_IDLE: begin
				reqReady = tmrBus.done;
				if (reqValid && tmrBus.done) begin
					next_op = reqOp;
					next_row = reqRow;
					next_col = reqCol;
					next_wdata = reqData;
					next_sN = (reqOp == CDM_OP_REFRESH) && !reqCacheOnly;
					next_hit = lrrValid && (reqRow == last_read_row_reg);
					next_wrSel = (reqOp != CDM_OP_READ);
					next_refN = (reqOp != CDM_OP_REFRESH);
					next_calN = 1'b1;
					next_weN = 1'b1;
					next_gN = 1'b1;
					next_addr = reqRow;
					tmrBus.load = 1'b1;
					next_state = reqCacheOnly ? ST_CREAD : ST_SETUP;
				end
			end
			ST_SETUP: if (tmrBus.done) begin
				next_reN = 1'b0;
				next_state = ST_RFALL;
			end
			ST_RFALL: begin
				next_rh = (op == CDM_OP_READ) && hit;
				next_rm = (op == CDM_OP_READ) && !hit;
				if (op == CDM_OP_READ) begin
					next_lrr = row;
					next_lrrValid = 1'b1;
				end
				next_addr = ROW_W'(col);
				tmrBus.load = 1'b1;
				tmrBus.count = (op == CDM_OP_READ && hit) ? C_AC : C_RAC;
				next_gN = (op != CDM_OP_READ);
				case (op)
					CDM_OP_READ:  next_state = ST_RDATA;
					CDM_OP_WRITE: begin
						tmrBus.count = C_WP;
						next_oe = 1'b1;
						next_addr = ROW_W'(col);
						next_state = ST_WLATCH;
					end
					default: begin
						tmrBus.count = C_RE;
						next_state = ST_RHOLD;
					end
				endcase
			end
			ST_RDATA: if (tmrBus.done) begin
				next_rdat = dqSync;
				next_rv = 1'b1;
				next_gN = 1'b1;
				tmrBus.load = 1'b1;
				tmrBus.count = hit ? C_RE1 : C_SU;
				next_state = ST_RHOLD;
			end
			ST_WLATCH: begin
				next_calN = 1'b0;
				next_weN = 1'b0;
				if (tmrBus.done && !calN) begin
					next_calN = 1'b1;
					next_weN = 1'b1;
					next_oe = 1'b0;
					next_rv = 1'b1;
					tmrBus.load = 1'b1;
					tmrBus.count = C_RSW;
					next_state = ST_WEND;
				end
			end
			ST_WEND: if (tmrBus.done) begin
				next_state = ST_RHOLD;
			end
			ST_RHOLD: if (tmrBus.done) begin
				next_reN = 1'b1;
				next_prech = (op == CDM_OP_READ && hit) ? C_RP1 : C_RP;
				tmrBus.load = 1'b1;
				if (op != CDM_OP_READ && op != CDM_OP_REFRESH && !hit) begin
					tmrBus.count = C_WRR;
				end else begin
					tmrBus.count = next_prech;
				end
				next_state = ST_PRECH;
			end
			ST_PRECH: if (tmrBus.done) begin
				next_sN = 1'b1;
				next_state = ST_IDLE;
			end
			ST_CREAD: begin
				// read cache with row enable high
				next_gN = 1'b0;
				next_addr = ROW_W'(col);
				if (tmrBus.done) begin
					tmrBus.load = 1'b1;
					tmrBus.count = C_AC;
					next_state = ST_RECOV;
				end
			end
			ST_RECOV: if (tmrBus.done) begin
				next_rdat = dqSync;
				next_rv = 1'b1;
				next_gN = 1'b1;
				next_sN = 1'b1;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;   op <= CDM_OP_READ; row <= '0; col <= '0;
			wdata <= '0;        hit <= 1'b0;       prech <= '0;
			last_read_row_reg <= '0;          lrrValid <= 1'b0;  reN <= 1'b1;
			wrSel <= 1'b0;      refN <= 1'b1;      calN <= 1'b1;
			weN <= 1'b1;        gN <= 1'b1;        sN <= 1'b1;
			addr <= '0;         oe <= 1'b0;        rv <= 1'b0;
			rh <= 1'b0;         rm <= 1'b0;        rdat <= '0;
		end else begin
			state <= next_state; op <= next_op;     row <= next_row;
			col <= next_col;     wdata <= next_wdata; hit <= next_hit;
			prech <= next_prech; last_read_row_reg <= next_lrr;
			lrrValid <= next_lrrValid; reN <= next_reN;
			wrSel <= next_wrSel; refN <= next_refN; calN <= next_calN;
			weN <= next_weN;     gN <= next_gN;     sN <= next_sN;
			addr <= next_addr;   oe <= next_oe;     rv <= next_rv;
			rh <= next_rh;       rm <= next_rm;     rdat <= next_rdat;
		end
	end

	assign row_enable_n     = reN;
	assign write_read_sel   = wrSel;
	assign refresh_n        = refN;
	assign col_addr_latch_n = calN;
	assign data_strobe_n    = weN;
	assign output_gate_n    = gN;
	assign chip_sel_n       = sN;
	assign mux_addr         = addr;
	assign data_io_out      = wdata;
	assign data_io_oe       = oe;
	assign rspValid         = rv;
	assign rspData          = rdat;
	assign rspHit           = hit;
	assign readHit          = rh;
	assign readMiss         = rm;
	assign lastReadRow      = last_read_row_reg;
	assign lastReadRowValid = lrrValid;
endmodule : cdm_host

/* File: cdm_cfg.svh */
// Constants and timing counts for the cached DRAM host controller.
// Assumes a 200 MHz clock; times in ns are converted to cycles here.
// Contract
// - More columns read by new addresses; static column or pulsed latch. The host reads one column per row cycle.
// - Write starts with write_read_sel, refresh_n, latch and strobe high.
// - Second burst write after fixed delay, later ones at page cycle. The host writes one column per row cycle, with no bursts.
// - Write ends with strobes high and row-active minimum; then precharge.
// - No read, write or row refresh while chip select is high.
`ifndef CDM_CFG_SVH
`define CDM_CFG_SVH

`define CDM_CLK_NS        5
`define CDM_CYC_MIN(ns)   (((ns) + `CDM_CLK_NS - 1) / `CDM_CLK_NS)
// Minimum times in ns, as printed for the slower grade
`define CDM_T_RAC_NS      35
`define CDM_T_AC_NS       15
`define CDM_T_RE_NS       35
`define CDM_T_RE1_NS      15
`define CDM_T_RP_NS       20
`define CDM_T_RP1_NS      10
`define CDM_T_RSW_NS      51
`define CDM_T_PC_NS       20
`define CDM_T_WP_NS       7
`define CDM_T_WRR_NS      20
`define CDM_T_SETUP_NS    6

`define CDM_ROW_W         11
`define CDM_COL_W         9
`define CDM_DATA_W        4
`define CDM_CNT_W         8

`endif

/* File: cdm_pkg.sv */
// Types for the cached DRAM host controller.
// Assumes cdm_cfg.svh is included by each user.
package cdm_pkg;
	typedef enum logic [1:0] {
		CDM_OP_READ,
		CDM_OP_WRITE,
		CDM_OP_REFRESH,
		CDM_OP_ROWREF
	} cdm_op_t;
endpackage : cdm_pkg

/* File: cdm_tmr_if.sv */
// Carrier between controller and its wait counter.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`include "cdm_cfg.svh"
interface cdm_tmr_if;
	logic                  load;
	logic [`CDM_CNT_W-1:0] count;
	logic                  done;
	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface : cdm_tmr_if

/* File: cdm_wait_timer.sv */
// Down counter that times one pin phase of the controller.
// Assumes load is a single cycle pulse with a nonzero count.
`timescale 1ns/1ps
`include "cdm_cfg.svh"
module cdm_wait_timer (
	input wire logic clk,
	input wire logic rst,
	cdm_tmr_if.tmr   tmr
);
	import cdm_pkg::*;
	logic [`CDM_CNT_W-1:0] left;
	logic [`CDM_CNT_W-1:0] next_left;

	always_comb begin
		next_left = left;
		if (tmr.load) begin
			next_left = tmr.count;
		end else if (left != '0) begin
			next_left = left - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			left <= '0;
		end else begin
			left <= next_left;
		end
	end

	// Done depends on the count only; load is derived from done upstream
	assign tmr.done = (left == '0);
endmodule : cdm_wait_timer

/* File: cdm_host_monitor.sv */
// Checker on the host controller pins and status ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module cdm_host_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic reqReady,
	input wire logic readHit,
	input wire logic readMiss,
	input wire logic lastReadRowValid,
	input wire logic row_enable_n,
	input wire logic write_read_sel,
	input wire logic refresh_n,
	input wire logic col_addr_latch_n,
	input wire logic data_strobe_n,
	input wire logic output_gate_n,
	input wire logic chip_sel_n,
	input wire logic data_io_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_read_latch_high: assert property (
		$fell(row_enable_n) && refresh_n |-> col_addr_latch_n)
		else $error("column latch low at row start");
	a_write_start_high: assert property (
		$fell(row_enable_n) && write_read_sel && refresh_n
		|-> data_strobe_n) else $error("strobe low at write start");
	a_no_fall_deselect: assert property (
		$fell(row_enable_n) && chip_sel_n |-> !refresh_n)
		else $error("row start while deselected");
	a_read_outcome_seen: assert property (
		$fell(row_enable_n) && refresh_n && !write_read_sel
		|-> ##[0:2] (readHit || readMiss))
		else $error("read cycle without outcome pulse");
	a_outcome_in_read: assert property (
		readHit || readMiss
		|-> !row_enable_n && !write_read_sel && refresh_n)
		else $error("outcome pulse outside read cycle");
	a_hit_miss_excl: assert property (
		!(readHit && readMiss)) else $error("hit and miss together");
	a_miss_sets_mirror: assert property (
		readMiss |-> ##[0:3] lastReadRowValid)
		else $error("mirror not valid after miss");
	a_commit_drives_bus: assert property (
		!col_addr_latch_n && !data_strobe_n |-> data_io_oe)
		else $error("write commit without data driven");
	a_no_bus_fight: assert property (
		!output_gate_n |-> !data_io_oe) else $error("bus contention");
	a_write_end_high: assert property (
		$rose(row_enable_n) && write_read_sel
		|-> col_addr_latch_n && data_strobe_n)
		else $error("strobes low at write end");
	a_idle_deselect: assert property (
		reqReady |-> row_enable_n && chip_sel_n && !data_io_oe)
		else $error("idle with device active");
	cover property (readHit);
	cover property (readMiss);
	cover property ($fell(row_enable_n) && !refresh_n);
	cover property ($rose(row_enable_n) && write_read_sel);
endmodule : cdm_host_monitor

bind cdm_host cdm_host_monitor u_mon (.clk(clk), .rst(rst),
	.reqReady(reqReady), .readHit(readHit), .readMiss(readMiss),
	.lastReadRowValid(lastReadRowValid), .row_enable_n(row_enable_n),
	.write_read_sel(write_read_sel), .refresh_n(refresh_n),
	.col_addr_latch_n(col_addr_latch_n), .data_strobe_n(data_strobe_n),
	.output_gate_n(output_gate_n), .chip_sel_n(chip_sel_n),
	.data_io_oe(data_io_oe));

/* File: cdm_dram_model.sv */
// Behavioural cached DRAM answering the host controller pins.
// Assumes pins move on the host clock; it has no reset of its own.
`timescale 1ns/1ps
module cdm_dram_model (
	input  wire logic        row_enable_n,
	input  wire logic        write_read_sel,
	input  wire logic        refresh_n,
	input  wire logic        col_addr_latch_n,
	input  wire logic        data_strobe_n,
	input  wire logic        output_gate_n,
	input  wire logic        chip_sel_n,
	input  wire logic [10:0] mux_addr,
	input  wire logic [3:0]  data_io_out,
	output logic      [3:0]  data_io_in
);
	logic [3:0]  arr [int] = '{default: 4'h0};
	logic [3:0]  cache [512];
	logic [10:0] lastReadRowReg, rowLat;
	logic [8:0]  col;
	logic        lrrOk = 0, inWr = 0, wrHit = 0, blk = 0;
	logic [3:0]  q = 4'h0;
	int          refCnt = 0, errs = 0, hits = 0, misses = 0;
	wire         drv = !chip_sel_n && !output_gate_n && !blk;
	// Strobes seen after the address and data that move with them
	wire #1      calD = col_addr_latch_n;
	wire #1      wsD = data_strobe_n;
	function automatic int key(logic [10:0] r, int c);
		return r * 512 + c;
	endfunction : key
	initial foreach (cache[i]) cache[i] = 4'h0;
	always @* if (calD) col = mux_addr[8:0];
	always @(negedge row_enable_n) begin
		rowLat = mux_addr;
		if (chip_sel_n && refresh_n) errs++;
		if (refresh_n && !(col_addr_latch_n && data_strobe_n)) errs++;
		if (!refresh_n) refCnt++;
		else if (!write_read_sel) begin
			if (lrrOk && mux_addr == lastReadRowReg) hits++;
			else begin
				misses++;
				foreach (cache[c]) cache[c] = arr[key(mux_addr, c)];
			end
			lrrOk = 1;
			lastReadRowReg = mux_addr;
		end else begin
			inWr = 1;
			wrHit = lrrOk && mux_addr == lastReadRowReg;
			blk = !wrHit;
		end
	end
	always @(posedge row_enable_n) begin
		inWr = 0;
		#19 blk = 0;
	end
	always @(calD, wsD)
		if (inWr && !calD && !wsD) begin
			arr[key(rowLat, col)] = data_io_out;
			if (wrHit) cache[col] = data_io_out;
		end
	always @* if (drv) q = cache[col];
	always @(negedge drv) q = ~q;
	assign data_io_in = q;
endmodule : cdm_dram_model

/* File: testbench.sv */
// Self-checking bench: host controller driving the DRAM model.
// Assumes the model needs no reset and answers on data_io_in.
`timescale 1ns/1ps
module testbench;
	import cdm_pkg::*;
	typedef struct {
		cdm_op_t     op;
		logic [10:0] row;
		logic [8:0]  col;
		logic [3:0]  dat;
		logic        only;
		logic [3:0]  expD;
		logic        expH;
	} cdm_case_t;
	localparam int N = 11;
	cdm_case_t rows [N] = '{
		'{CDM_OP_WRITE, 11'h005, 9'h003, 4'hA, 1'h0, 4'h0, 1'h0},
		'{CDM_OP_READ, 11'h005, 9'h003, 4'h0, 1'h0, 4'hA, 1'h0},
		'{CDM_OP_READ, 11'h005, 9'h003, 4'h0, 1'h0, 4'hA, 1'h1},
		'{CDM_OP_WRITE, 11'h005, 9'h007, 4'h6, 1'h0, 4'h0, 1'h0},
		'{CDM_OP_READ, 11'h005, 9'h007, 4'h0, 1'h1, 4'h6, 1'h0},
		'{CDM_OP_WRITE, 11'h009, 9'h007, 4'h3, 1'h0, 4'h0, 1'h0},
		'{CDM_OP_READ, 11'h005, 9'h007, 4'h0, 1'h1, 4'h6, 1'h0},
		'{CDM_OP_ROWREF, 11'h009, 9'h007, 4'hF, 1'h0, 4'h0, 1'h0},
		'{CDM_OP_REFRESH, 11'h000, 9'h000, 4'h0, 1'h0, 4'h0, 1'h0},
		'{CDM_OP_READ, 11'h009, 9'h007, 4'h0, 1'h0, 4'h3, 1'h0},
		'{CDM_OP_READ, 11'h005, 9'h007, 4'h0, 1'h0, 4'h6, 1'h0}};
	logic        clk, rst = 1'h1, reqValid = 1'h0, reqCacheOnly = 1'h0;
	cdm_op_t     reqOp = CDM_OP_READ;
	logic [10:0] reqRow = 11'h000, lastReadRow, mux_addr;
	logic [8:0]  reqCol = 9'h000;
	logic [3:0]  reqData = 4'h0, rspData, data_io_in, data_io_out, gotD;
	logic        reqReady, rspValid, rspHit, readHit, readMiss, gotH;
	logic        row_enable_n, write_read_sel, refresh_n, data_io_oe;
	logic        col_addr_latch_n, data_strobe_n, output_gate_n;
	logic        chip_sel_n, lastReadRowValid;
	int          bad_count = 0, checks = 0, nHit = 0, nMiss = 0;
	cdm_host uut (.clk(clk), .rst(rst), .reqValid(reqValid),
		.reqReady(reqReady), .reqOp(reqOp), .reqRow(reqRow),
		.reqCol(reqCol), .reqData(reqData), .reqCacheOnly(reqCacheOnly),
		.rspValid(rspValid), .rspData(rspData), .rspHit(rspHit),
		.readHit(readHit), .readMiss(readMiss), .lastReadRow(lastReadRow),
		.lastReadRowValid(lastReadRowValid), .row_enable_n(row_enable_n),
		.write_read_sel(write_read_sel), .refresh_n(refresh_n),
		.col_addr_latch_n(col_addr_latch_n), .data_strobe_n(data_strobe_n),
		.output_gate_n(output_gate_n), .chip_sel_n(chip_sel_n),
		.mux_addr(mux_addr), .data_io_in(data_io_in),
		.data_io_out(data_io_out), .data_io_oe(data_io_oe));
	cdm_dram_model dev (.row_enable_n(row_enable_n),
		.write_read_sel(write_read_sel), .refresh_n(refresh_n),
		.col_addr_latch_n(col_addr_latch_n), .data_strobe_n(data_strobe_n),
		.output_gate_n(output_gate_n), .chip_sel_n(chip_sel_n),
		.mux_addr(mux_addr), .data_io_out(data_io_out),
		.data_io_in(data_io_in));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rspValid) begin
			gotD <= rspData;
			gotH <= rspHit;
		end
		if (readHit) nHit++;
		if (readMiss) nMiss++;
	end
	task automatic check(string name, logic [10:0] seen, logic [10:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		if (bad_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	// Holds the request until taken, then waits for idle again
	task automatic issue(cdm_case_t r);
		int n;
		n = 0;
		@(negedge clk);
		gotD = 4'hX;
		{reqValid, reqOp, reqRow, reqCol} = {1'h1, r.op, r.row, r.col};
		{reqData, reqCacheOnly} = {r.dat, r.only};
		while (!reqReady && n < 300) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		reqValid = 1'h0;
		do begin
			@(negedge clk);
			n++;
		end while (!reqReady && n < 300);
		// Response pulse may land with ready; let the capture edge pass
		@(negedge clk);
		if (n >= 300) check("timeout", 11'h001, 11'h000);
	endtask : issue
	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'h0;
		for (int i = 0; i < N; i++) begin
			issue(rows[i]);
			if (rows[i].op == CDM_OP_READ) begin
				check("rspData", 11'(gotD), 11'(rows[i].expD));
				if (!rows[i].only) check("rspHit", 11'(gotH), 11'(rows[i].expH));
			end
		end
		check("devHits", 11'(dev.hits), 11'h001);
		check("devMisses", 11'(dev.misses), 11'h003);
		check("readHit", 11'(nHit), 11'h001);
		check("readMiss", 11'(nMiss), 11'h003);
		check("refresh", 11'(dev.refCnt), 11'h001);
		check("protocol", 11'(dev.errs), 11'h000);
		check("lastReadRow", lastReadRow, 11'h005);
		@(negedge clk);
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		check("mirrorValid", 11'(lastReadRowValid), 11'h000);
		check("idlePins", 11'({row_enable_n, chip_sel_n, data_io_oe}), 11'h006);
		issue(rows[1]);
		check("rspData", 11'(gotD), 11'h00A);
		check("rspHit", 11'(gotH), 11'h000);
		end_of_test();
	end
endmodule : testbench
